// >>> hdl/osc_ready_timer.v
`default_nettype none
// Counts oscillator cycles after a restart and flags the oscillator stable
module osc_ready_timer (
   // Clock and reset
   input wire sys_clk_i,
   input wire rstn_i,
   // Control
   input wire restart_i,
   input wire tick_i,
   input wire [9:0] target_i,
   // Status
   output reg done_o
);
   reg [9:0] count;

   // Restart dominates so a stopped oscillator can never look ready
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count <= 10'h000;
         done_o <= 1'b0;
      end else if (restart_i) begin
         count <= 10'h000;
         done_o <= 1'b0;
      end else if (tick_i && !done_o) begin
         count <= count + 10'h001;
         if (count + 10'h001 >= target_i) begin
            done_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/power_mode_clock_controller.v
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "power_mode_clock_controller_defs.vh"
// Overview of operation
// - Select bit high picks undivided fast clock
// - Switching to subclock turns fast oscillator off
// - Idle clock keep bit decides idle clock
// - Flag register bits six to three read zero
// - Fast wake only from watchdog sleep, idle-off
// - Crystal fast wake: subclock until 512 cycles
// - RC fast oscillator ignores fast wake, fixed latency
// - Watchdog off: slow oscillator off unless on subclock or in idle-off, no fast wake
// - Mode via select/divider; halt via idle bits
// - On subclock, fast divided outputs stop too
// - Slow switch waits for slow stable flag
// - Deep sleep stops all clocks, halts watchdog
// - Watchdog sleep: watchdog counts on subclock
// - Idle-off keeps time base and subclock
// - Power-down sets flag, clears expiry flag unless an expiry arrives in that cycle
// - Idle-on keeps system clock running
// - Fast flag after 512 or 16 cycles
// - Slow flag after 128 or 2 cycles
`default_nettype none
module power_mode_clock_controller (
   // Clock and reset
   input wire sys_clk_i,
   input wire rstn_i,
   // Register port
   input wire [1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // CPU events
   input wire halt_i,
   input wire wake_i,
   input wire wdog_clear_insn_i,
   input wire wdog_timeout_i,
   input wire [2:0] reset_cause_set_i,
   // System configuration and oscillator cycle ticks
   input wire wdog_enable_i,
   input wire lvd_enable_i,
   input wire fast_is_crystal_i,
   input wire slow_is_crystal_i,
   input wire fast_tick_i,
   input wire sub_tick_i,
   // Clock controls
   output reg [1:0] sys_src_o,
   output reg [2:0] div_sel_o,
   output reg sys_clk_en_o,
   output reg fast_osc_en_o,
   output reg fast_div_en_o,
   output reg slow_osc_en_o,
   output reg wdog_clk_en_o,
   output reg timebase_clk_en_o,
   // CPU status
   output reg cpu_run_o,
   output reg wdog_clear_o,
   output reg power_down_flag_o,
   output reg wdog_expiry_flag_o,
   output reg [2:0] mode_o
);
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_DEEP_SLEEP = 3'h1;
   localparam [2:0] ST_SLEEP_WDOG = 3'h2;
   localparam [2:0] ST_IDLE_OFF = 3'h3;
   localparam [2:0] ST_IDLE_ON = 3'h4;
   localparam [2:0] ST_WAKE = 3'h5;

   reg [7:0] system_mode_reg;
   reg [7:0] power_control_flags;
   reg [2:0] state;
   reg [2:0] next_state;
   reg temp_sub;
   reg next_temp_sub;
   reg fast_wake_armed;
   reg next_fast_wake_armed;
   reg [1:0] wake_ticks;
   reg [1:0] next_wake_ticks;
   reg enter_pd;
   wire fast_done;
   wire slow_done;

   // True when the divider setting routes the subclock in
   function picks_sub;
      input [7:0] smr;
      begin
         picks_sub = !smr[`SMR_CLOCK_SELECT] && (smr[`SMR_DIV_MSB:`SMR_DIV_LSB] <= `DIV_LAST_SUB);
      end
   endfunction

   wire clock_select_bit = system_mode_reg[`SMR_CLOCK_SELECT];
   wire idle_select = system_mode_reg[`SMR_IDLE_SELECT];
   wire fast_wake_enable = system_mode_reg[`SMR_FAST_WAKE];
   wire [2:0] clock_divider_field = system_mode_reg[`SMR_DIV_MSB:`SMR_DIV_LSB];
   wire idle_clock_keep = power_control_flags[`PCF_IDLE_CLOCK_KEEP];
   wire sub_sel = picks_sub(system_mode_reg);
   wire fast_osc_stable_flag = fast_done;
   wire slow_osc_stable_flag = slow_done;

   // Fast oscillator runs only in awake states and while not on the subclock
   wire fast_run = (state == ST_RUN || state == ST_IDLE_ON || state == ST_WAKE) && !sub_sel;
   // Low-speed side follows the watchdog, except while it is the system clock or
   // idle-off needs the subclock for the time base
   wire slow_run = (state != ST_DEEP_SLEEP) &&
                   (wdog_enable_i || sub_sel || state == ST_IDLE_OFF);
   // Flag of the clock the core currently runs from
   wire src_ready = (temp_sub || sub_sel) ? slow_done : fast_done;
   wire halt_ok = (state == ST_RUN) && halt_i && cpu_run_o;

   // Settle counts follow the oscillator kind actually fitted
   osc_ready_timer u_fast_timer (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .restart_i(!fast_run),
      .tick_i(fast_tick_i),
      .target_i(fast_is_crystal_i ? `FAST_XTAL_SETTLE : `FAST_RC_SETTLE),
      .done_o(fast_done)
   );

   osc_ready_timer u_slow_timer (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .restart_i(!slow_run),
      .tick_i(sub_tick_i),
      .target_i(slow_is_crystal_i ? `SLOW_XTAL_SETTLE : `SLOW_RC_SETTLE),
      .done_o(slow_done)
   );

   // Mode sequencing on halt and wake
   always @* begin
      next_state = state;
      next_temp_sub = temp_sub;
      next_fast_wake_armed = fast_wake_armed;
      next_wake_ticks = wake_ticks;
      enter_pd = 1'b0;
      case (state)
         ST_RUN: begin
            // Temporary subclock ends once the fast oscillator has settled
            if (temp_sub && fast_done) begin
               next_temp_sub = 1'b0;
            end
            if (halt_ok) begin
               enter_pd = 1'b1;
               if (idle_select && idle_clock_keep) begin
                  next_state = ST_IDLE_ON;
               end else if (idle_select) begin
                  next_state = ST_IDLE_OFF;
               end else if (!wdog_enable_i && !lvd_enable_i) begin
                  next_state = ST_DEEP_SLEEP;
               end else begin
                  next_state = ST_SLEEP_WDOG;
               end
            end
         end
         ST_IDLE_ON: begin
            // Clock never stopped, so the core resumes at once
            if (wake_i) begin
               next_state = ST_RUN;
            end
         end
         ST_DEEP_SLEEP: begin
            // Subclock is stopped here, so fast wake never arms
            if (wake_i) begin
               next_state = ST_WAKE;
               next_fast_wake_armed = 1'b0;
               next_wake_ticks = 2'h0;
            end
         end
         ST_SLEEP_WDOG, ST_IDLE_OFF: begin
            if (wake_i) begin
               next_state = ST_WAKE;
               // Only a crystal fast oscillator with a live subclock benefits
               next_fast_wake_armed = fast_wake_enable && fast_is_crystal_i && !sub_sel &&
                                      slow_done && wdog_enable_i;
               next_wake_ticks = 2'h0;
            end
         end
         ST_WAKE: begin
            if (fast_wake_armed) begin
               if (sub_tick_i) begin
                  next_wake_ticks = wake_ticks + 2'h1;
               end
               if (sub_tick_i && (wake_ticks + 2'h1 >= `FAST_WAKE_SUB_TICKS)) begin
                  next_state = ST_RUN;
                  next_temp_sub = !fast_done;
                  next_fast_wake_armed = 1'b0;
               end
            end else if (src_ready) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // State registers
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_RUN;
         temp_sub <= 1'b0;
         fast_wake_armed <= 1'b0;
         wake_ticks <= 2'h0;
      end else begin
         state <= next_state;
         temp_sub <= next_temp_sub;
         fast_wake_armed <= next_fast_wake_armed;
         wake_ticks <= next_wake_ticks;
      end
   end

   // Software registers; the reset cause flags let hardware set win over a clear
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         system_mode_reg <= `SMR_RESET;
         power_control_flags <= `PCF_RESET;
      end else begin
         if (wr_i && addr_i == `REG_SYSTEM_MODE) begin
            // Stable flags are owned by the timers and not stored here
            system_mode_reg <= wdata_i & 8'hf3;
         end
         if (wr_i && addr_i == `REG_POWER_CONTROL_FLAGS) begin
            power_control_flags <= {wdata_i[7], 4'h0,
                                    wdata_i[`PCF_CAUSE_MSB:0] | reset_cause_set_i};
         end else begin
            power_control_flags[`PCF_CAUSE_MSB:0] <=
               power_control_flags[`PCF_CAUSE_MSB:0] | reset_cause_set_i;
         end
      end
   end

   // Read data one cycle after the strobe; unmapped indices read zero
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `REG_SYSTEM_MODE: begin
               rdata_o <= {clock_divider_field, fast_wake_enable, slow_osc_stable_flag,
                           fast_osc_stable_flag, idle_select, clock_select_bit};
            end
            `REG_POWER_CONTROL_FLAGS: begin
               rdata_o <= {idle_clock_keep, 4'h0,
                           power_control_flags[`PCF_CAUSE_MSB:0]};
            end
            default: begin
               rdata_o <= 8'h00;
            end
         endcase
      end
   end

   // Status flags; an expiry in the same cycle as a halt still counts
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_down_flag_o <= 1'b0;
         wdog_expiry_flag_o <= 1'b0;
         wdog_clear_o <= 1'b0;
      end else begin
         wdog_clear_o <= enter_pd && wdog_enable_i;
         if (enter_pd) begin
            power_down_flag_o <= 1'b1;
         end else if (wdog_clear_insn_i) begin
            power_down_flag_o <= 1'b0;
         end
         if (wdog_timeout_i) begin
            wdog_expiry_flag_o <= 1'b1;
         end else if (enter_pd) begin
            wdog_expiry_flag_o <= 1'b0;
         end
      end
   end

   // Registered clock controls
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sys_src_o <= `SRC_FAST;
         div_sel_o <= 3'h0;
         sys_clk_en_o <= 1'b0;
         fast_osc_en_o <= 1'b1;
         fast_div_en_o <= 1'b0;
         slow_osc_en_o <= 1'b0;
         wdog_clk_en_o <= 1'b0;
         timebase_clk_en_o <= 1'b0;
         cpu_run_o <= 1'b0;
         mode_o <= ST_RUN;
      end else begin
         if (temp_sub || sub_sel) begin
            sys_src_o <= `SRC_SUB;
         end else if (clock_select_bit) begin
            sys_src_o <= `SRC_FAST;
         end else begin
            sys_src_o <= `SRC_FAST_DIV;
         end
         div_sel_o <= clock_divider_field;
         // Gated until settled so no edge comes from an unstable source
         sys_clk_en_o <= ((state == ST_RUN) && src_ready) || (state == ST_IDLE_ON);
         fast_osc_en_o <= fast_run;
         fast_div_en_o <= fast_run && fast_done;
         slow_osc_en_o <= slow_run;
         wdog_clk_en_o <= wdog_enable_i && (state != ST_DEEP_SLEEP);
         timebase_clk_en_o <= (state == ST_RUN) || (state == ST_IDLE_ON) ||
                              (state == ST_IDLE_OFF);
         // Halt or a pending switch both freeze execution
         cpu_run_o <= (next_state == ST_RUN) && (state == ST_RUN || state == ST_WAKE) &&
                      !halt_ok && src_ready;
         mode_o <= state;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/power_mode_clock_controller_defs.vh
`ifndef POWER_MODE_CLOCK_CONTROLLER_DEFS_VH
`define POWER_MODE_CLOCK_CONTROLLER_DEFS_VH
// Register indices on the plain register port
`define REG_SYSTEM_MODE 2'h0
`define REG_POWER_CONTROL_FLAGS 2'h1
// System mode register fields
`define SMR_CLOCK_SELECT 0
`define SMR_IDLE_SELECT 1
`define SMR_FAST_STABLE 2
`define SMR_SLOW_STABLE 3
`define SMR_FAST_WAKE 4
`define SMR_DIV_LSB 5
`define SMR_DIV_MSB 7
`define SMR_RESET 8'h01
// Power control flags register fields
`define PCF_IDLE_CLOCK_KEEP 7
`define PCF_CAUSE_MSB 2
`define PCF_RESET 8'h00
// Divider codes at or below this value pick the subclock
`define DIV_LAST_SUB 3'h1
// Source select codes on sys_src_o
`define SRC_FAST 2'h0
`define SRC_FAST_DIV 2'h1
`define SRC_SUB 2'h2
// Oscillator settling counts, in cycles of the oscillator itself
`define FAST_XTAL_SETTLE 10'h200
`define FAST_RC_SETTLE 10'h010
`define SLOW_XTAL_SETTLE 10'h080
`define SLOW_RC_SETTLE 10'h002
// Subclock cycles for a fast wake-up
`define FAST_WAKE_SUB_TICKS 2'h2
`endif

// >>> sim/power_mode_clock_controller_properties.sv
`include "power_mode_clock_controller_defs.vh"
`default_nettype none
// Port-level relations between halt entry, clock gating and flags
module power_mode_clock_controller_properties (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Events and levels
   input wire logic halt_i,
   input wire logic wdog_timeout_i,
   input wire logic wdog_enable_i,
   // Clock controls and status
   input wire logic [1:0] sys_src_o,
   input wire logic sys_clk_en_o,
   input wire logic fast_osc_en_o,
   input wire logic fast_div_en_o,
   input wire logic slow_osc_en_o,
   input wire logic wdog_clk_en_o,
   input wire logic timebase_clk_en_o,
   input wire logic cpu_run_o,
   input wire logic wdog_clear_o,
   input wire logic power_down_flag_o,
   input wire logic wdog_expiry_flag_o,
   input wire logic [2:0] mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // A halt only counts while the core is running
   logic taken;
   assign taken = halt_i && cpu_run_o && (mode_o == 3'h0);

   a_rsvd_read_zero: assert property (rd_i && addr_i == `REG_POWER_CONTROL_FLAGS
      |=> rdata_o[6:3] == 4'h0) else $error("flag register reserved bits not zero");
   a_halt_sets_flags: assert property (taken && !wdog_timeout_i ##1 !wdog_timeout_i
      |=> power_down_flag_o && !wdog_expiry_flag_o) else $error("halt flags wrong");
   a_wdog_cleared: assert property (taken && wdog_enable_i
      |-> ##[1:2] wdog_clear_o) else $error("watchdog not cleared on halt");
   a_deep_all_off: assert property (mode_o == 3'h1
      |-> !(sys_clk_en_o || wdog_clk_en_o || timebase_clk_en_o)) else $error("deep sleep clock on");
   a_wsleep_wdog_on: assert property (mode_o == 3'h2 && wdog_enable_i
      |-> wdog_clk_en_o && !sys_clk_en_o && !timebase_clk_en_o) else $error("wdog sleep clocks");
   a_idle_off_clks: assert property (mode_o == 3'h3
      |-> !sys_clk_en_o && timebase_clk_en_o && slow_osc_en_o) else $error("idle-off clocks");
   a_idle_on_clk: assert property (mode_o == 3'h4 |-> sys_clk_en_o)
      else $error("idle-on system clock off");
   a_div_taps_off: assert property (!fast_osc_en_o |-> !fast_div_en_o)
      else $error("divided taps run without fast oscillator");
   // Excludes the fast wake window, where the core runs from the subclock
   a_sel_fast: assert property (wr_i && addr_i == `REG_SYSTEM_MODE && wdata_i[0] && cpu_run_o
      && sys_src_o != `SRC_SUB |-> ##[1:3] sys_src_o == `SRC_FAST) else $error("fast not selected");
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`include "power_mode_clock_controller_defs.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic halt_i = 1'b0, wake_i = 1'b0, wdog_clear_insn_i = 1'b0, wdog_timeout_i = 1'b0;
   logic wdog_enable_i = 1'b1, lvd_enable_i = 1'b0, fast_is_crystal_i = 1'b1;
   logic slow_is_crystal_i = 1'b0, fast_tick_i = 1'b0, sub_tick_i = 1'b0;
   logic [1:0] addr_i = 2'h0, sys_src_o;
   logic [7:0] wdata_i = 8'h00, rdata_o, d;
   logic [2:0] reset_cause_set_i = 3'h0, div_sel_o, mode_o;
   logic sys_clk_en_o, fast_osc_en_o, fast_div_en_o, slow_osc_en_o, wdog_clk_en_o;
   logic timebase_clk_en_o, cpu_run_o, wdog_clear_o, power_down_flag_o, wdog_expiry_flag_o;
   logic [6:0] t;
   // Halt table: idle select, keep, watchdog, detector, expected state
   logic [6:0] tbl [6] = '{7'h01, 7'h0a, 7'h12, 7'h53, 7'h43, 7'h74};
   int n_errors = 0, n_compared = 0, i;

   power_mode_clock_controller DUT (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .halt_i, .wake_i, .wdog_clear_insn_i, .wdog_timeout_i, .reset_cause_set_i,
      .wdog_enable_i, .lvd_enable_i, .fast_is_crystal_i, .slow_is_crystal_i, .fast_tick_i,
      .sub_tick_i, .sys_src_o, .div_sel_o, .sys_clk_en_o, .fast_osc_en_o, .fast_div_en_o,
      .slow_osc_en_o, .wdog_clk_en_o, .timebase_clk_en_o, .cpu_run_o, .wdog_clear_o,
      .power_down_flag_o, .wdog_expiry_flag_o, .mode_o);

   // 200 MHz system clock
   initial forever #2.5 sys_clk_i = ~sys_clk_i;

   // Oscillator ticks at irregular spacing, as a real oscillator would not align
   always @(posedge sys_clk_i) begin
      fast_tick_i <= 1'($urandom_range(1));
      sub_tick_i <= ($urandom_range(3) == 0);
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(posedge sys_clk_i);
      v = rdata_o;
   endtask

   // 0 halt, 1 wake, 2 clear instruction, 3 watchdog expiry
   task automatic pulse(input int s);
      @(posedge sys_clk_i);
      {halt_i, wake_i, wdog_clear_insn_i, wdog_timeout_i} <= 4'h8 >> s;
      @(posedge sys_clk_i);
      {halt_i, wake_i, wdog_clear_insn_i, wdog_timeout_i} <= 4'h0;
   endtask

   task automatic wait_run(input logic [1:0] src, input logic any);
      for (i = 0; i < 4000; i++) begin
         @(posedge sys_clk_i);
         if (cpu_run_o === 1'b1 && (any || sys_src_o === src))
            break;
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(69059));
      repeat (2) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      wait_run(`SRC_FAST, 1'b0);
      rd(`REG_SYSTEM_MODE, d);
      chk("mode reg", 8'h05, d & 8'hf7);
      rd(`REG_POWER_CONTROL_FLAGS, d);
      chk("flags reg", `PCF_RESET, d);
      rd(2'h3, d);
      chk("unmapped", 8'h00, d);
      wr(`REG_POWER_CONTROL_FLAGS, 8'hff);
      rd(`REG_POWER_CONTROL_FLAGS, d);
      chk("flags bits", 8'h87, d);
      d = {3'($urandom_range(7, 2)), 5'h00};
      wr(`REG_SYSTEM_MODE, d);
      repeat (3) @(posedge sys_clk_i);
      chk("div src", `SRC_FAST_DIV, sys_src_o);
      chk("div sel", d[7:5], div_sel_o);
      $display("register and divider test done");
      // Every halt outcome, each with fast wake enabled and a pending expiry
      foreach (tbl[k]) begin
         t = tbl[k];
         wdog_enable_i <= t[4];
         lvd_enable_i <= t[3];
         wr(`REG_POWER_CONTROL_FLAGS, {t[5], 7'h00});
         wr(`REG_SYSTEM_MODE, {6'h04, t[6], 1'b1});
         repeat (1000) @(posedge sys_clk_i);
         pulse(3);
         pulse(0);
         repeat (3) @(posedge sys_clk_i);
         chk("state", t[2:0], mode_o);
         chk("pd flag", 1'b1, power_down_flag_o);
         chk("expiry", 1'b0, wdog_expiry_flag_o);
         chk("sys clk", t[2], sys_clk_en_o);
         chk("wdog clk", t[4], wdog_clk_en_o);
         pulse(1);
         wait_run(`SRC_FAST, 1'b1);
         chk("wake src", (t[1] && t[4]) ? `SRC_SUB : `SRC_FAST, sys_src_o);
         wait_run(`SRC_FAST, 1'b0);
         chk("back on fast", `SRC_FAST, sys_src_o);
         pulse(2);
         repeat (2) @(posedge sys_clk_i);
         chk("pd cleared", 1'b0, power_down_flag_o);
         $display("halt test %h done", t);
      end
      // Subclock request stops the fast oscillator; then return to fast
      wr(`REG_SYSTEM_MODE, 8'h20);
      wait_run(`SRC_SUB, 1'b0);
      chk("sub src", `SRC_SUB, sys_src_o);
      chk("fast osc", 1'b0, fast_osc_en_o);
      chk("fast taps", 1'b0, fast_div_en_o);
      rd(`REG_SYSTEM_MODE, d);
      chk("stable flags", 8'h08, d & 8'h0c);
      wr(`REG_SYSTEM_MODE, 8'h01);
      wait_run(`SRC_FAST, 1'b0);
      rd(`REG_SYSTEM_MODE, d);
      chk("fast flag", 8'h04, d & 8'h04);
      t = 7'($urandom_range(7, 1));
      @(posedge sys_clk_i);
      reset_cause_set_i <= t[2:0];
      @(posedge sys_clk_i);
      reset_cause_set_i <= 3'h0;
      rd(`REG_POWER_CONTROL_FLAGS, d);
      chk("cause flags", {5'h10, t[2:0]}, d);
      $display("clock switch test done");
      // RC fast oscillator: fast wake bit has no effect, short settle
      fast_is_crystal_i <= 1'b0;
      wr(`REG_SYSTEM_MODE, 8'h13);
      wr(`REG_POWER_CONTROL_FLAGS, 8'h00);
      pulse(0);
      pulse(1);
      wait_run(`SRC_FAST, 1'b1);
      chk("rc wake src", `SRC_FAST, sys_src_o);
      chk("rc wake quick", 8'h01, 8'(i < 100));
      $display("rc wake test done");
      tally_and_finish();
   end

   // Cuts a hang short; the sequence needs about 14000 cycles
   initial begin
      #300000;
      n_errors++;
      tally_and_finish();
   end
endmodule

bind power_mode_clock_controller power_mode_clock_controller_properties props (.sys_clk_i,
   .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .halt_i, .wdog_timeout_i,
   .wdog_enable_i, .sys_src_o, .sys_clk_en_o, .fast_osc_en_o, .fast_div_en_o, .slow_osc_en_o,
   .wdog_clk_en_o, .timebase_clk_en_o, .cpu_run_o, .wdog_clear_o, .power_down_flag_o,
   .wdog_expiry_flag_o, .mode_o);
`default_nettype wire
